//--- bench/lpm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_pin_model (
  // Clock
  input wire logic clk_in,
  // Board side
  input wire logic [9:0] level_in,
  input wire logic [9:0] drive_low_in,
  // Device pins
  output logic [9:0] port_pin_out,
  output logic int_osc_out,
  output logic ext_osc_out
);
  logic [3:0] cnt_q = 4'h0;
  // Open-drain pins read low wherever the device pulls them down.
  assign port_pin_out = level_in & ~drive_low_in;
  // The oscillators run far faster than real parts so that a PWM period fits the run.
  assign int_osc_out = cnt_q[2];
  // The external clock stays many system clocks long, so every edge is seen.
  assign ext_osc_out = cnt_q[3];
  always @(posedge clk_in) begin
    cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

//--- bench/lpm_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_regs_checker #(
  parameter logic EXT_OSC_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire lpm_pkg::lpm_bus_req_type bus_in,
  input wire logic [7:0] rd_data_out,
  // Pins and status
  input wire logic [9:0] port_pin_in,
  input wire lpm_pkg::lpm_pin_drive_type pin_drive_out,
  input wire logic int_osc_in,
  input wire logic ext_osc_in,
  input wire logic cs_wake_in,
  input wire logic dout_oe_out,
  input wire logic run_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  chk_cfg_d6_zero: assert property ($past(bus_in.rd && bus_in.addr == 8'h10) |->
    !rd_data_out[6]) else $error("config bit 6 read as one");
  chk_in_hi_zero: assert property ($past(bus_in.rd && bus_in.addr == 8'h0f) |->
    rd_data_out[7:2] == 6'h00) else $error("upper input bits not zero");
  chk_status_excl: assert property ($past(bus_in.rd && bus_in.addr == 8'h10) |->
    !(rd_data_out[3] && rd_data_out[4]) && !(|rd_data_out[4:3] && rd_data_out[0]))
    else $error("hold or fade status with run bit");
  chk_ramp_run: assert property ($past(bus_in.rd && bus_in.addr == 8'h10) && rd_data_out[2]
    |-> rd_data_out[0] && rd_data_out[4:3] == 2'b00) else $error("ramp status without run");
  chk_in_mask: assert property ($past(bus_in.rd && bus_in.addr == 8'h0e)
    && $stable(pin_drive_out.in_buf_en) |-> (rd_data_out & ~pin_drive_out.in_buf_en[7:0]) == 8'h00)
    else $error("input bit set for a non-input port");
  chk_shut_sinks: assert property ((!run_out) [*3] |-> pin_drive_out.sink_on == 10'h000)
    else $error("sink active in shutdown");
  chk_sink_excl: assert property ((pin_drive_out.sink_on
    & (pin_drive_out.in_buf_en | pin_drive_out.drive_low)) == 10'h000)
    else $error("sink port with logic drive or buffer");
  chk_dout_role: assert property ($past(bus_in.rd && bus_in.addr == 8'h10) && $stable(dout_oe_out)
    |-> rd_data_out[7] == !dout_oe_out) else $error("data output role differs from bit 7");
  chk_unmapped_zero: assert property ($past(bus_in.rd && bus_in.addr > 8'h10
    && bus_in.addr != 8'h18) |-> rd_data_out == 8'h00) else $error("unmapped read not zero");
  cover property ($past(bus_in.rd && bus_in.addr == 8'h10) && rd_data_out[2]);
  cover property ($past(bus_in.rd && bus_in.addr == 8'h10) && rd_data_out[4]);
  cover property (pin_drive_out.sink_on[1] != pin_drive_out.sink_on[0]);
endmodule
`default_nettype wire

//--- bench/lpm_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module led_port_mode_and_io_regs_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  lpm_pkg::lpm_bus_req_type bus = '0;
  lpm_pkg::lpm_pin_drive_type drv;
  logic [7:0] rdat;
  logic [9:0] pins;
  logic [9:0] lvl = 10'h000;
  logic cs = 1'b0;
  logic iosc, eosc, dout_oe, run;
  logic [7:0] rdat_x;
  logic dout_oe_x;
  int mismatches = 0;
  int tests_run = 0;
  integer seed = 32'h2bd0;
  int mdl [10];
  int c0, c1, cx;
  always #5 clk_in = ~clk_in;
  lpm_regs #(.EXT_OSC_DEFAULT(1'b0)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus),
    .rd_data_out(rdat), .port_pin_in(pins), .pin_drive_out(drv), .int_osc_in(iosc),
    .ext_osc_in(eosc), .cs_wake_in(cs), .dout_oe_out(dout_oe), .run_out(run));
  // Second variant, strapped to the external clock, shares every input.
  lpm_regs #(.EXT_OSC_DEFAULT(1'b1)) i_dut_ext (.clk_in(clk_in), .rst_in(rst_in), .bus_in(bus),
    .rd_data_out(rdat_x), .port_pin_in(pins), .pin_drive_out(), .int_osc_in(iosc),
    .ext_osc_in(eosc), .cs_wake_in(cs), .dout_oe_out(dout_oe_x), .run_out());
  lpm_pin_model i_pins (.clk_in(clk_in), .level_in(lvl), .drive_low_in(drv.drive_low),
    .port_pin_out(pins), .int_osc_out(iosc), .ext_osc_out(eosc));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts are exact to one oscillator tick, which the margin absorbs.
  task automatic near(input int got, input int exp);
    check(10'(got >= exp - 12 && got <= exp + 12), 10'h001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 check(10'(rdat), 10'(exp));
  endtask
  task automatic wp(input logic [7:0] a, input logic [7:0] d);
    int lo, hi;
    lo = (a == 8'h0c) ? 4 : (a == 8'h0d) ? 8 : (a > 8'h09) ? 0 : int'(a);
    hi = (a == 8'h0b) ? 3 : (a == 8'h0c) ? 7 : (a > 8'h09) ? 9 : int'(a);
    wr(a, d);
    for (int i = lo; i <= hi; i++) mdl[i] = int'(d);
  endtask
  task automatic ports();
    for (int i = 0; i < 10; i++) rc(8'(i), 8'(mdl[i]));
  endtask
  task automatic cs_pulse();
    @(posedge clk_in) cs <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  task automatic meas(input int n);
    c0 = 0;
    c1 = 0;
    cx = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      c0 += int'(drv.sink_on[0]);
      c1 += int'(drv.sink_on[1]);
      cx += int'(drv.sink_on[0] ^ drv.sink_on[1]);
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    #600us;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 check(10'(dout_oe), 10'h001);
    check(10'(dout_oe_x), 10'h000);
    check(drv.sink_on | drv.drive_low | drv.in_buf_en, 10'h000);
    for (int i = 0; i < 10; i++) mdl[i] = 255;
    ports();
    rc(8'h10, 8'h00);
    check(10'(rdat_x), 10'h080);
    rc(8'h20, 8'h00);
    for (int i = 0; i < 10; i++) wp(8'(i), 8'($random(seed)));
    ports();
    for (int a = 10; a < 14; a++) begin
      wp(8'(a), 8'($random(seed)));
      ports();
    end
    rc(8'h0a, 8'(mdl[0]));
    rc(8'h0b, 8'(mdl[0]));
    rc(8'h0c, 8'(mdl[4]));
    rc(8'h0d, 8'(mdl[8]));
    wr(8'h0e, 8'h5a);
    wr(8'h0f, 8'ha5);
    ports();
    wp(8'h0a, 8'h01);
    wp(8'h03, 8'hff);
    wp(8'h09, 8'h00);
    @(posedge clk_in) lvl <= 10'($random(seed));
    repeat (4) @(posedge clk_in);
    #1 check(drv.in_buf_en, 10'h3f7);
    check(drv.drive_low, 10'h200);
    rc(8'h0e, lvl[7:0] & 8'hf7);
    rc(8'h0f, {7'h00, lvl[8]});
    wr(8'h10, 8'h40);
    rc(8'h10, 8'h00);
    wr(8'h10, 8'ha2);
    rc(8'h10, 8'ha2);
    check(10'(dout_oe), 10'h000);
    wr(8'h10, 8'h00);
    cs_pulse();
    rc(8'h10, 8'h00);
    wr(8'h10, 8'h02);
    cs_pulse();
    rc(8'h10, 8'h03);
    check(10'(run), 10'h001);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h00);
    wr(8'h18, 8'h10);
    wr(8'h10, 8'h01);
    rc(8'h10, 8'h01);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h08);
    wr(8'h10, 8'h01);
    rc(8'h10, 8'h01);
    wr(8'h18, 8'h21);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h10);
    repeat (3000) @(posedge clk_in);
    rc(8'h10, 8'h08);
    repeat (4000) @(posedge clk_in);
    rc(8'h10, 8'h00);
    wr(8'h10, 8'h05);
    rc(8'h10, 8'h05);
    repeat (5000) @(posedge clk_in);
    rc(8'h10, 8'h01);
    wp(8'h00, 8'h80);
    wp(8'h01, 8'h03);
    wp(8'h02, 8'h02);
    meas(2048);
    check(10'(drv.sink_on[2]), 10'h001);
    near(c0, 1024);
    near(c1, 24);
    wr(8'h18, 8'h00);
    wr(8'h10, 8'h00);
    wp(8'h01, 8'h80);
    wr(8'h10, 8'h20);
    wr(8'h10, 8'h21);
    meas(2048);
    near(cx, 512);
    // The external clock ticks every 16 cycles, so one period is 4096 cycles.
    wr(8'h10, 8'ha1);
    meas(4096);
    near(c0, 2048);
    near(cx, 1024);
    end_of_test();
  end
endmodule
bind lpm_regs lpm_regs_checker #(.EXT_OSC_DEFAULT(EXT_OSC_DEFAULT)) i_chk (.clk_in(clk_in),
  .rst_in(rst_in), .bus_in(bus_in), .rd_data_out(rd_data_out), .port_pin_in(port_pin_in),
  .pin_drive_out(pin_drive_out), .int_osc_in(int_osc_in), .ext_osc_in(ext_osc_in),
  .cs_wake_in(cs_wake_in), .dout_oe_out(dout_oe_out), .run_out(run_out));
`default_nettype wire

//--- shared/lpm_consts.svh
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LPM_ADDR_PORT0 8'h00
`define LPM_ADDR_PORT9 8'h09
`define LPM_ADDR_ALL 8'h0a
`define LPM_ADDR_GRP_LO 8'h0b
`define LPM_ADDR_GRP_MID 8'h0c
`define LPM_ADDR_GRP_HI 8'h0d
`define LPM_ADDR_IN_LO 8'h0e
`define LPM_ADDR_IN_HI 8'h0f
`define LPM_ADDR_CFG 8'h10
`define LPM_ADDR_SEQ 8'h18

// ****************************************************************
// Configuration fields
// ****************************************************************
`define LPM_CFG_RUN 0
`define LPM_CFG_CSRUN 1
`define LPM_CFG_RAMP 2
`define LPM_CFG_FADE 3
`define LPM_CFG_HOLD 4
`define LPM_CFG_STAGGER 5
`define LPM_CFG_OSC 7

// ****************************************************************
// Port codes, PWM and reset values
// ****************************************************************
`define LPM_CODE_LOW 8'h00
`define LPM_CODE_INPUT 8'h01
`define LPM_CODE_SINK 8'h02
`define LPM_CODE_HIZ 8'hff
`define LPM_PORT_RESET 8'hff
`define LPM_SEQ_RESET 8'h00
`define LPM_STAGGER_STEP 8'h20
`define LPM_NUM_PORTS 10

`endif

//--- shared/lpm_pkg.sv
package lpm_pkg;

  typedef enum logic [2:0] {
    LPM_SHUTDOWN = 3'b000,
    LPM_RAMP_UP = 3'b001,
    LPM_RUN = 3'b010,
    LPM_HOLD_OFF = 3'b011,
    LPM_FADE_OFF = 3'b100
  } lpm_mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lpm_bus_req_type;

  typedef struct packed {
    logic [9:0] sink_on;
    logic [9:0] drive_low;
    logic [9:0] in_buf_en;
  } lpm_pin_drive_type;

endpackage

//--- verilog/lpm_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpm_consts.svh"

module lpm_regs #(
  parameter logic EXT_OSC_DEFAULT = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire lpm_pkg::lpm_bus_req_type bus_in,
  output logic [7:0] rd_data_out,
  // Port pins
  input wire logic [9:0] port_pin_in,
  output lpm_pkg::lpm_pin_drive_type pin_drive_out,
  // PWM clock sources, wakeup, data output enable and run status
  input wire logic int_osc_in,
  input wire logic ext_osc_in,
  input wire logic cs_wake_in,
  output logic dout_oe_out,
  output logic run_out
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [9:0] wr_mask(input logic [7:0] addr);
    logic [9:0] m;
    m = 10'h000;
    // Group addresses cover ports 0 to 3, 4 to 7 and 8 to 9.
    if (addr <= `LPM_ADDR_PORT9) begin
      m[addr[3:0]] = 1'b1;
    end else if (addr == `LPM_ADDR_ALL) begin
      m = 10'h3ff;
    end else if (addr == `LPM_ADDR_GRP_LO) begin
      m = 10'h00f;
    end else if (addr == `LPM_ADDR_GRP_MID) begin
      m = 10'h0f0;
    end else if (addr == `LPM_ADDR_GRP_HI) begin
      m = 10'h300;
    end
    // Input register addresses give an empty mask, so writes there vanish.
    return m;
  endfunction

  function automatic logic is_pwm_code(input logic [7:0] code);
    return (code > `LPM_CODE_SINK) && (code != `LPM_CODE_HIZ);
  endfunction

  // Status bits in read-back order: hold-off, fade-off, ramp-up, run.
  function automatic logic [3:0] mode_bits(input lpm_pkg::lpm_mode_type mode);
    logic [3:0] b;
    b = 4'h0;
    unique case (mode)
      lpm_pkg::LPM_SHUTDOWN: begin
        b = 4'b0000;
      end
      lpm_pkg::LPM_RAMP_UP: begin
        b = 4'b0011;
      end
      lpm_pkg::LPM_RUN: begin
        b = 4'b0001;
      end
      lpm_pkg::LPM_HOLD_OFF: begin
        b = 4'b1000;
      end
      lpm_pkg::LPM_FADE_OFF: begin
        b = 4'b0100;
      end
      default: begin
        b = 4'b0000;
      end
    endcase
    return b;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_s2_q;
  logic [2:0] ctl_s3_q;

  always_ff @(posedge clk_in) begin
    pin_s1_q <= port_pin_in;
    pin_s2_q <= pin_s1_q;
    ctl_s1_q <= {cs_wake_in, ext_osc_in, int_osc_in};
    ctl_s2_q <= ctl_s1_q;
    ctl_s3_q <= ctl_s2_q;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] port_q [`LPM_NUM_PORTS];
  logic osc_sel_q;
  logic stagger_q;
  logic cs_run_q;
  logic [7:0] seq_q;
  logic osc_init_q;
  lpm_pkg::lpm_mode_type mode_q;
  logic [9:0] wmask;
  logic cfg_wr;
  logic [7:0] wd;

  assign wmask = bus_in.wr ? wr_mask(bus_in.addr) : 10'h000;
  assign cfg_wr = bus_in.wr && (bus_in.addr == `LPM_ADDR_CFG);
  assign wd = bus_in.wdata;

  genvar gi;
  generate
    for (gi = 0; gi < `LPM_NUM_PORTS; gi++) begin : g_port_reg
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          port_q[gi] <= `LPM_PORT_RESET;
        end else if (wmask[gi]) begin
          port_q[gi] <= wd;
        end
      end
    end
  endgenerate

  // The strap value is a parameter, so it is loaded one clock after reset
  // release rather than wired into the reset branch.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stagger_q <= 1'b0;
      cs_run_q <= 1'b0;
      osc_init_q <= 1'b1;
      osc_sel_q <= 1'b0;
    end else begin
      osc_init_q <= 1'b0;
      if (osc_init_q) begin
        osc_sel_q <= EXT_OSC_DEFAULT;
      end else if (cfg_wr) begin
        osc_sel_q <= wd[`LPM_CFG_OSC];
      end
      if (cfg_wr) begin
        // Bit D6 has no storage at all.
        stagger_q <= wd[`LPM_CFG_STAGGER];
        cs_run_q <= wd[`LPM_CFG_CSRUN];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seq_q <= `LPM_SEQ_RESET;
    end else if (bus_in.wr && (bus_in.addr == `LPM_ADDR_SEQ)) begin
      seq_q <= wd;
    end
  end

  // ****************************************************************
  // PWM timebase
  // ****************************************************************
  logic pwm_tick;
  logic [7:0] pwm_cnt_q;
  logic period_end;

  // Only the synchronised copies are edge-detected; the external source
  // must stay well below the system clock for every edge to be seen.
  assign pwm_tick = osc_sel_q ? (ctl_s2_q[1] && !ctl_s3_q[1]) :
                                (ctl_s2_q[0] && !ctl_s3_q[0]);
  assign period_end = pwm_tick && (pwm_cnt_q == 8'hff);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwm_cnt_q <= 8'h00;
    end else if (pwm_tick) begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  // ****************************************************************
  // Mode sequencer
  // ****************************************************************
  logic [3:0] seq_cnt_q;
  logic cs_wake;
  logic [3:0] hold_len;
  logic [3:0] fade_len;

  assign cs_wake = ctl_s2_q[2] && !ctl_s3_q[2] && cs_run_q;
  assign hold_len = seq_q[3:0];
  assign fade_len = seq_q[7:4];

  // The PWM counter runs free, in shutdown too, so the first period of a
  // hold-off, fade-off or ramp-up phase may be a partial one.
  // Keeping one shared timebase avoids a restart glitch on running ports.

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_q <= lpm_pkg::LPM_SHUTDOWN;
      seq_cnt_q <= 4'h0;
    end else if (cfg_wr && wd[`LPM_CFG_RUN]) begin
      unique case (mode_q)
        lpm_pkg::LPM_SHUTDOWN: begin
          if (wd[`LPM_CFG_RAMP] && (fade_len != 4'h0)) begin
            mode_q <= lpm_pkg::LPM_RAMP_UP;
            seq_cnt_q <= fade_len;
          end else begin
            mode_q <= lpm_pkg::LPM_RUN;
          end
        end
        lpm_pkg::LPM_HOLD_OFF, lpm_pkg::LPM_FADE_OFF: begin
          mode_q <= lpm_pkg::LPM_RUN;
        end
        lpm_pkg::LPM_RAMP_UP, lpm_pkg::LPM_RUN: begin
          mode_q <= mode_q;
        end
        default: begin
          mode_q <= lpm_pkg::LPM_SHUTDOWN;
        end
      endcase
    end else if (cfg_wr) begin
      unique case (mode_q)
        lpm_pkg::LPM_RAMP_UP, lpm_pkg::LPM_RUN: begin
          if (hold_len != 4'h0) begin
            mode_q <= lpm_pkg::LPM_HOLD_OFF;
            seq_cnt_q <= hold_len;
          end else if (fade_len != 4'h0) begin
            mode_q <= lpm_pkg::LPM_FADE_OFF;
            seq_cnt_q <= fade_len;
          end else begin
            mode_q <= lpm_pkg::LPM_SHUTDOWN;
          end
        end
        lpm_pkg::LPM_SHUTDOWN, lpm_pkg::LPM_HOLD_OFF, lpm_pkg::LPM_FADE_OFF: begin
          mode_q <= mode_q;
        end
        default: begin
          mode_q <= lpm_pkg::LPM_SHUTDOWN;
        end
      endcase
    end else if (cs_wake && (mode_q == lpm_pkg::LPM_SHUTDOWN)) begin
      mode_q <= lpm_pkg::LPM_RUN;
    end else if (period_end && (mode_q != lpm_pkg::LPM_SHUTDOWN) &&
                 (mode_q != lpm_pkg::LPM_RUN)) begin
      if (seq_cnt_q > 4'h1) begin
        seq_cnt_q <= seq_cnt_q - 4'h1;
      end else if (mode_q == lpm_pkg::LPM_HOLD_OFF && fade_len != 4'h0) begin
        mode_q <= lpm_pkg::LPM_FADE_OFF;
        seq_cnt_q <= fade_len;
      end else if (mode_q == lpm_pkg::LPM_RAMP_UP) begin
        mode_q <= lpm_pkg::LPM_RUN;
      end else begin
        mode_q <= lpm_pkg::LPM_SHUTDOWN;
      end
    end
  end

  // ****************************************************************
  // Port drivers
  // ****************************************************************
  logic active;
  logic [9:0] input_mode;

  assign active = (mode_q != lpm_pkg::LPM_SHUTDOWN);

  generate
    // Ports 8 and 9 reuse the offsets of ports 0 and 1, since the period
    // holds only eight phase slots.
    for (gi = 0; gi < `LPM_NUM_PORTS; gi++) begin : g_port_drv
      logic [7:0] phase;
      logic [7:0] offset;
      assign offset = stagger_q ? 8'((gi % 8) * `LPM_STAGGER_STEP) : 8'h00;
      assign phase = pwm_cnt_q - offset;
      assign input_mode[gi] = (port_q[gi] == `LPM_CODE_INPUT);

      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          pin_drive_out.sink_on[gi] <= 1'b0;
          pin_drive_out.drive_low[gi] <= 1'b0;
          pin_drive_out.in_buf_en[gi] <= 1'b0;
        end else begin
          // Logic codes stay live in shutdown; sinks float there.
          pin_drive_out.drive_low[gi] <= (port_q[gi] == `LPM_CODE_LOW);
          pin_drive_out.in_buf_en[gi] <= input_mode[gi] ||
                                         (port_q[gi] == `LPM_CODE_LOW);
          if (!active) begin
            pin_drive_out.sink_on[gi] <= 1'b0;
          end else if (port_q[gi] == `LPM_CODE_SINK) begin
            pin_drive_out.sink_on[gi] <= 1'b1;
          end else if (is_pwm_code(port_q[gi])) begin
            pin_drive_out.sink_on[gi] <= (phase < port_q[gi]);
          end else begin
            pin_drive_out.sink_on[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read-back
  // ****************************************************************
  logic [9:0] in_levels;
  logic [7:0] cfg_rd;
  logic [3:0] mode_rd;
  logic [7:0] rd_mux;

  // Only the input code opens a level to software; the static-low logic
  // code keeps its buffer on but always reads zero.
  assign in_levels = pin_s2_q & input_mode;
  assign mode_rd = mode_bits(mode_q);
  assign cfg_rd = {osc_sel_q, 1'b0, stagger_q,
                   mode_rd[3:1], cs_run_q, mode_rd[0]};

  always_comb begin
    rd_mux = 8'h00;
    if (bus_in.addr <= `LPM_ADDR_PORT9) begin
      rd_mux = port_q[bus_in.addr[3:0]];
    end else if (bus_in.addr == `LPM_ADDR_ALL || bus_in.addr == `LPM_ADDR_GRP_LO) begin
      rd_mux = port_q[0];
    end else if (bus_in.addr == `LPM_ADDR_GRP_MID) begin
      rd_mux = port_q[4];
    end else if (bus_in.addr == `LPM_ADDR_GRP_HI) begin
      rd_mux = port_q[8];
    end else if (bus_in.addr == `LPM_ADDR_IN_LO) begin
      rd_mux = in_levels[7:0];
    end else if (bus_in.addr == `LPM_ADDR_IN_HI) begin
      rd_mux = {6'h00, in_levels[9:8]};
    end else if (bus_in.addr == `LPM_ADDR_CFG) begin
      rd_mux = cfg_rd;
    end else if (bus_in.addr == `LPM_ADDR_SEQ) begin
      rd_mux = seq_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else begin
      // Idle cycles return zero, so read data can be merged by a plain OR.
      rd_data_out <= bus_in.rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dout_oe_out <= 1'b0;
      run_out <= 1'b0;
    end else begin
      dout_oe_out <= !osc_sel_q && !osc_init_q;
      run_out <= active;
    end
  end

endmodule
`default_nettype wire
